/* File: logic/ees_fifo.sv */
// Write-data buffer between the serial receiver and the memory array.
// Assumes DEPTH is a power of two; clear drops all entries at once.
`timescale 1ns/1ps
`default_nettype none
module ees_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  // Storage and pointers
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } ees_fifo_state_t;

  ees_fifo_state_t q;
  ees_fifo_state_t n;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = q.cnt != (PW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state
  always_comb begin
    n = q;
    if (clear) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[q.wp] = in_data;
        n.wp = q.wp + 1'b1;
      end
      if (pop) begin
        n.rp = q.rp + 1'b1;
      end
      case ({push, pop})
        2'b10: n.cnt = q.cnt + 1'b1;
        2'b01: n.cnt = q.cnt - 1'b1;
        default: n.cnt = q.cnt;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : ees_fifo
`default_nettype wire

/* File: logic/ees_i2c_port.sv */
// Serial two-wire slave port of the EEPROM: framing, select, write and read.
// Assumes the bus lines arrive asynchronously and the master drives the clock.
// What this block does
// - Data falling while clock high is Start.
// - Ignore everything until a Start appears.
// - Data rising while clock high is Stop.
// - Nack then Stop in read gives standby.
// - Receiver pulls data low on ninth pulse.
// - Sample data on rising clock edges.
// - Block radio side while port is busy.
// - Start-to-first-clock timeout resets the port.
// - Clock high or low too long resets.
// - Select is 1010, area bit, two ones.
// - Select bit eight: one read, zero write.
// - Ack matching select, else release and standby.
// - Two address bytes, high byte first.
// - Locked without key: nack data, no change.
// - Only Stop in tenth slot starts programming.
// - After programming, counter follows last byte.
// - Programming: data line released, no answers.
// - Page up to four bytes, wraps in row.
// - Busy programming: select gets no ack.
// - Reads ignore the write lock.
// - Each read advances the address by one.
// - Area bit one reaches the system area.
// - Data high at read ack ends transmit.
`timescale 1ns/1ps
`default_nettype none
module ees_i2c_port #(
  parameter int ADDR_W = 13,
  parameter int FIFO_DEPTH = ees_pkg::FIFO_DEPTH,
  parameter int unsigned START_TMO_CYC = ees_pkg::START_TO_CLOCK_TIMEOUT_CYC,
  parameter int unsigned HIGH_TMO_CYC = ees_pkg::CLOCK_HIGH_WIDTH_CYC,
  parameter int unsigned LOW_TMO_CYC = ees_pkg::CLOCK_LOW_WIDTH_CYC,
  parameter int unsigned PROG_CYC = ees_pkg::PROGRAM_CYCLE_TIME_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic write_lock,
  input wire logic unlock_key_valid,
  output logic radio_block
);
  localparam int CW = ees_pkg::CNT_W;
  localparam int FW = ees_pkg::FIFO_W;
  localparam logic [CW-1:0] START_LIM = CW'(START_TMO_CYC);
  localparam logic [CW-1:0] HIGH_LIM = CW'(HIGH_TMO_CYC);
  localparam logic [CW-1:0] LOW_LIM = CW'(LOW_TMO_CYC);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYC - 1);

  ees_pkg::ees_port_t q; // Registered state
  ees_pkg::ees_port_t n; // Its next value

  // Bus events, all from the second synchroniser stage onward
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic tmo_hit;
  logic [CW-1:0] tmo_lim;
  logic dev_match;
  logic data_locked;

  // Buffer and memory hookup
  logic fifo_push;
  logic fifo_flush;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic drain;
  logic [7:0] mem_rdata;

  assign scl_rise = q.scl_s & ~q.scl_p;
  assign scl_fall = ~q.scl_s & q.scl_p;
  assign start_ev = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_ev = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  // Type nibble and fixed enable bits; area bit is free
  assign dev_match = (q.shreg[ees_pkg::SEL_TYPE_MSB:ees_pkg::SEL_TYPE_LSB] == ees_pkg::DEV_TYPE) &&
    (q.shreg[ees_pkg::SEL_CE_MSB:ees_pkg::SEL_CE_LSB] == ees_pkg::CE_FIXED);
  assign data_locked = write_lock & ~unlock_key_valid;
  // Before the first clock rise the start limit applies, then the width limits
  assign tmo_lim = (q.st == ees_pkg::ST_DEV && !q.clk_seen) ? START_LIM : (q.scl_s ? HIGH_LIM : LOW_LIM);
  assign tmo_hit = (q.st != ees_pkg::ST_IDLE) && (q.st != ees_pkg::ST_WCYC) && (q.tmo >= tmo_lim);
  assign drain = (q.st == ees_pkg::ST_WCYC); // Buffer drains into the array only while programming

  // Open drain: only ever pull low, enable does the work
  assign sda_out = 1'b0;
  assign sda_oe_n = q.oe_n;
  assign radio_block = (q.st != ees_pkg::ST_IDLE);

  // Next-state logic of the whole port
  always_comb begin
    n = q;
    fifo_push = 1'b0;
    fifo_flush = 1'b0;
    // Two-stage synchronisers, then one history stage
    n.scl_m = scl_in;
    n.sda_m = sda_in;
    n.scl_s = q.scl_m;
    n.sda_s = q.sda_m;
    n.scl_p = q.scl_s;
    n.sda_p = q.sda_s;
    // Timeout restarts on clock edges and Start, saturates; before the first rise only the Start counts
    if (scl_rise || start_ev || (scl_fall && (q.st != ees_pkg::ST_DEV || q.clk_seen))) begin
      n.tmo = '0;
    end else if (q.tmo != '1) begin
      n.tmo = q.tmo + 1'b1;
    end
    if (q.st == ees_pkg::ST_WCYC) begin
      // Programming: line released, Starts and selects ignored
      n.oe_n = 1'b1;
      if (fifo_out_valid) begin
        n.last_addr = fifo_out_data[FW-2:8];
        n.wrote = 1'b1;
      end
      if (q.wcnt >= PROG_LAST && !fifo_out_valid) begin
        n.st = ees_pkg::ST_IDLE;
        if (q.wrote) begin
          n.addr = q.last_addr + 16'h0001;
        end
      end else begin
        n.wcnt = q.wcnt + 1'b1;
      end
    end else if (start_ev) begin
      // Start, also a repeated one, opens a fresh select
      n.st = ees_pkg::ST_DEV;
      n.bitcnt = '0;
      n.in_ack = 1'b0;
      n.clk_seen = 1'b0;
      n.stop_ok = 1'b0;
      n.oe_n = 1'b1;
      fifo_flush = 1'b1;
    end else if (stop_ev) begin
      n.oe_n = 1'b1;
      if (q.st == ees_pkg::ST_WDATA && q.stop_ok) begin
        // Stop right after a data ack: begin the timed write
        n.st = ees_pkg::ST_WCYC;
        n.wcnt = '0;
        n.wrote = 1'b0;
      end else begin
        // Any other Stop ends the exchange; stale data dropped
        n.st = ees_pkg::ST_IDLE;
        fifo_flush = 1'b1;
      end
    end else if (tmo_hit) begin
      // Stuck clock or late first edge: back to waiting for Start
      n.st = ees_pkg::ST_IDLE;
      n.oe_n = 1'b1;
      fifo_flush = 1'b1;
    end else begin
      case (q.st)
        ees_pkg::ST_IDLE: begin
          // Waiting for a Start
          n.oe_n = 1'b1;
        end
        ees_pkg::ST_DEV, ees_pkg::ST_ADRH, ees_pkg::ST_ADRL, ees_pkg::ST_WDATA: begin
          if (scl_rise) begin
            n.clk_seen = 1'b1;
            // Tenth-slot window closes once a second bit is clocked
            if (q.bitcnt != '0) begin
              n.stop_ok = 1'b0;
            end
            if (!q.in_ack) begin
              n.shreg = {q.shreg[6:0], q.sda_s};
              n.bitcnt = q.bitcnt + 1'b1;
            end
          end
          if (scl_fall) begin
            if (q.in_ack) begin
              // Ninth pulse over: release and move on
              n.oe_n = 1'b1;
              n.in_ack = 1'b0;
              n.bitcnt = '0;
              case (q.st)
                ees_pkg::ST_DEV: begin
                  if (q.rw) begin
                    // First read bit goes out on this falling edge
                    n.st = ees_pkg::ST_RDATA;
                    n.tx = mem_rdata;
                    n.oe_n = mem_rdata[7];
                  end else begin
                    n.st = ees_pkg::ST_ADRH;
                  end
                end
                ees_pkg::ST_ADRH: n.st = ees_pkg::ST_ADRL;
                ees_pkg::ST_ADRL: n.st = ees_pkg::ST_WDATA;
                default: n.stop_ok = q.acked;
              endcase
            end else if (q.bitcnt == ees_pkg::BITS_PER_BYTE) begin
              // Eighth bit done: decide the acknowledge
              n.in_ack = 1'b1;
              n.acked = 1'b1;
              n.oe_n = 1'b0;
              case (q.st)
                ees_pkg::ST_DEV: begin
                  if (dev_match) begin
                    n.e2 = q.shreg[ees_pkg::SEL_SYS_BIT];
                    n.rw = q.shreg[ees_pkg::SEL_RW_BIT];
                  end else begin
                    // Not for us: stay off the bus until next Start
                    n.st = ees_pkg::ST_IDLE;
                    n.in_ack = 1'b0;
                    n.oe_n = 1'b1;
                  end
                end
                ees_pkg::ST_ADRH: n.addr[15:8] = q.shreg;
                ees_pkg::ST_ADRL: n.addr[7:0] = q.shreg;
                default: begin
                  if (!data_locked && fifo_in_ready) begin
                    fifo_push = 1'b1;
                    // In-row counter; upper bits stay so overrun wraps
                    n.addr[1:0] = q.addr[1:0] + 2'h1;
                  end else begin
                    // Locked or buffer full: leave the line high
                    n.acked = 1'b0;
                    n.oe_n = 1'b1;
                  end
                end
              endcase
            end
          end
        end
        ees_pkg::ST_RDATA: begin
          if (scl_rise) begin
            if (q.in_ack) begin
              if (q.sda_s) begin
                // Master declined: stop sending, wait for Stop idle
                n.st = ees_pkg::ST_IDLE;
                n.oe_n = 1'b1;
              end
            end else begin
              n.bitcnt = q.bitcnt + 1'b1;
            end
          end
          if (scl_fall) begin
            if (q.in_ack) begin
              // Master acked: next byte, its top bit now
              n.in_ack = 1'b0;
              n.bitcnt = '0;
              n.tx = mem_rdata;
              n.oe_n = mem_rdata[7];
            end else if (q.bitcnt == ees_pkg::BITS_PER_BYTE) begin
              // Release for the master's ack and move on a byte
              n.oe_n = 1'b1;
              n.in_ack = 1'b1;
              n.addr = q.addr + 16'h0001;
            end else begin
              n.tx = {q.tx[6:0], 1'b0};
              n.oe_n = q.tx[6];
            end
          end
        end
        default: begin
          n.st = ees_pkg::ST_IDLE;
          n.oe_n = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= ees_pkg::PORT_RST;
    end else begin
      q <= n;
    end
  end

  // Page buffer; back-pressure shows as a data nack
  ees_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clear(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({q.e2, q.addr, q.shreg}),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(fifo_out_data)
  );

  // Area bit selects the upper half of the array
  ees_mem #(
    .AW(ADDR_W + 1)
  ) u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .rd_addr({q.e2, q.addr[ADDR_W-1:0]}),
    .rd_data(mem_rdata),
    .we(fifo_out_valid & drain),
    .wr_addr({fifo_out_data[FW-1], fifo_out_data[ADDR_W+7:8]}),
    .wr_data(fifo_out_data[7:0])
  );

  // Checks on the sequencer
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  start_enters_select_a: assert property (start_ev && q.st != ees_pkg::ST_WCYC |=> q.st == ees_pkg::ST_DEV)
    else $error("Start did not open a select");
  idle_stays_quiet_a: assert property (q.st == ees_pkg::ST_IDLE && !start_ev |=> q.st == ees_pkg::ST_IDLE && q.oe_n)
    else $error("Idle port reacted without a Start");
  stop_ends_exchange_a: assert property (stop_ev && q.st != ees_pkg::ST_WCYC && !(q.st == ees_pkg::ST_WDATA && q.stop_ok)
    |=> q.st == ees_pkg::ST_IDLE)
    else $error("Stop did not end the exchange");
  select_ack_a: assert property (q.st == ees_pkg::ST_DEV && scl_fall && !q.in_ack
    && q.bitcnt == ees_pkg::BITS_PER_BYTE && dev_match |=> !q.oe_n [*1] ##0 q.in_ack)
    else $error("Matching select not acknowledged");
  select_miss_a: assert property (q.st == ees_pkg::ST_DEV && scl_fall && !q.in_ack
    && q.bitcnt == ees_pkg::BITS_PER_BYTE && !dev_match |=> q.st == ees_pkg::ST_IDLE && q.oe_n)
    else $error("Foreign select was answered");
  locked_nack_a: assert property (q.st == ees_pkg::ST_WDATA && scl_fall && !q.in_ack
    && q.bitcnt == ees_pkg::BITS_PER_BYTE && data_locked |-> !fifo_push ##1 q.oe_n)
    else $error("Locked data byte was taken");
  program_start_a: assert property (q.st == ees_pkg::ST_WDATA && stop_ev
    |=> (q.st == ees_pkg::ST_WCYC) == $past(q.stop_ok))
    else $error("Program cycle started from the wrong slot");
  program_quiet_a: assert property (q.st == ees_pkg::ST_WCYC |-> q.oe_n && q.wcnt <= PROG_LAST)
    else $error("Data line driven or timer overran in programming");
  radio_blocked_a: assert property (!q.oe_n |-> radio_block)
    else $error("Radio side not blocked while busy");
  timeout_reset_a: assert property (tmo_hit && !start_ev && !stop_ev |=> q.st == ees_pkg::ST_IDLE)
    else $error("Timeout did not reset the port");
  read_advance_a: assert property (q.st == ees_pkg::ST_RDATA && scl_fall && !q.in_ack
    && q.bitcnt == ees_pkg::BITS_PER_BYTE |=> q.addr == $past(q.addr) + 16'h0001)
    else $error("Read did not advance the address");
  read_nack_a: assert property (q.st == ees_pkg::ST_RDATA && q.in_ack && scl_rise && q.sda_s
    |=> q.st == ees_pkg::ST_IDLE && q.oe_n)
    else $error("Read went on after a master nack");

  write_cycle_c: cover property (q.st == ees_pkg::ST_WDATA && stop_ev && q.stop_ok);
  read_end_c: cover property (q.st == ees_pkg::ST_RDATA && q.in_ack && scl_rise && q.sda_s);
  timeout_c: cover property (tmo_hit);
  locked_write_c: cover property (q.st == ees_pkg::ST_WDATA && fifo_push == 1'b0 && data_locked && scl_fall);
endmodule : ees_i2c_port
`default_nettype wire

/* File: logic/ees_mem.sv */
// Byte array of both memory areas, one write and one registered read port.
// Assumes the caller holds the read address steady while it waits for data.
`timescale 1ns/1ps
`default_nettype none
module ees_mem #(
  parameter int AW = 14
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic we,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  // Array kept outside a struct: far too large for one packed vector
  logic [7:0] cells [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      cells[wr_addr] <= wr_data;
    end
  end

  // Registered read, one cycle behind the address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= cells[rd_addr];
    end
  end
endmodule : ees_mem
`default_nettype wire

/* File: logic/ees_pkg.sv */
// Shared constants and types for the serial EEPROM slave port.
// Assumes a single 25 MHz clock domain; all users reference items by package scope.
package ees_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // Bus timing limits, in microseconds (longest times, so cycles round down)
  localparam int unsigned START_TO_CLOCK_TIMEOUT_US = 35;
  localparam int unsigned CLOCK_HIGH_WIDTH_MAX_US = 25;
  localparam int unsigned CLOCK_LOW_WIDTH_MAX_US = 25;
  // Self-timed program duration, kept below the worst-case limit
  localparam int unsigned PROGRAM_CYCLE_TIME_US = 4000;

  // Derived cycle counts
  localparam int unsigned START_TO_CLOCK_TIMEOUT_CYC = START_TO_CLOCK_TIMEOUT_US * CYC_PER_US;
  localparam int unsigned CLOCK_HIGH_WIDTH_CYC = CLOCK_HIGH_WIDTH_MAX_US * CYC_PER_US;
  localparam int unsigned CLOCK_LOW_WIDTH_CYC = CLOCK_LOW_WIDTH_MAX_US * CYC_PER_US;
  localparam int unsigned PROGRAM_CYCLE_TIME_CYC = PROGRAM_CYCLE_TIME_US * CYC_PER_US;

  // Counter width for timeouts and the program cycle
  localparam int CNT_W = 20;

  // Select byte layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [1:0] CE_FIXED = 2'h3;
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_SYS_BIT = 3;
  localparam int SEL_CE_MSB = 2;
  localparam int SEL_CE_LSB = 1;
  localparam int SEL_RW_BIT = 0;

  // Byte framing and buffered write entry {area, address, data}
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int FIFO_W = 25;
  localparam int FIFO_DEPTH = 32;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // Port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_ADRH, ST_ADRL, ST_WDATA, ST_RDATA, ST_WCYC
  } ees_state_t;

  // Complete port state
  typedef struct packed {
    logic scl_m;
    logic sda_m;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
    ees_state_t st;
    logic [3:0] bitcnt;
    logic in_ack;
    logic acked;
    logic clk_seen;
    logic stop_ok;
    logic rw;
    logic e2;
    logic oe_n;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [15:0] addr;
    logic [15:0] last_addr;
    logic wrote;
    logic [CNT_W-1:0] tmo;
    logic [CNT_W-1:0] wcnt;
  } ees_port_t;

  // Value after reset: lines idle high, data line released
  localparam ees_port_t PORT_RST = '{scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
    scl_p: 1'b1, sda_p: 1'b1, oe_n: 1'b1, st: ST_IDLE, addr: ADDR_RESET, default: '0};

endpackage : ees_pkg

/* File: test/ees_i2c_port_tb_top.sv */
// Bench for the serial EEPROM port: master model, byte model, compares.
// Assumes short timeout and program counts set through parameters.
`timescale 1ns/1ps
`default_nettype none
module ees_i2c_port_tb_top;
  localparam int TMO = 100; // Well above a bus half period
  localparam int STMO = 60; // Start limit kept apart from the width limits
  localparam int PROG = 400;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_lock = 1'b0;
  logic unlock_key_valid = 1'b0;
  logic sda_out, sda_oe_n, radio_block;
  wire scl, sda_m, sda;
  logic [7:0] mem [int]; // Byte model keyed by {area, address}
  int fail_count = 0;
  int n_compared = 0;
  // Wire-AND of master and device, pulled up when both release
  assign sda = sda_m & (sda_oe_n | sda_out);
  always #20 clk = ~clk;
  ees_i2c_port #(.START_TMO_CYC(STMO), .HIGH_TMO_CYC(TMO), .LOW_TMO_CYC(TMO), .PROG_CYC(PROG)) u_dut (
    .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .write_lock(write_lock), .unlock_key_valid(unlock_key_valid), .radio_block(radio_block));
  ees_master u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Start and select byte
  task automatic sel(input logic e2, input logic rw, output logic k);
    u_mst.start();
    u_mst.wbyte({4'ha, e2, 2'b11, rw}, k);
  endtask : sel
  // Write select and two address bytes
  task automatic addr(input logic e2, input logic [15:0] a);
    logic k;
    sel(e2, 1'b0, k);
    chk("select ack", k, 1'b1);
    u_mst.wbyte(a[15:8], k);
    chk("addr hi ack", k, 1'b1);
    u_mst.wbyte(a[7:0], k);
    chk("addr lo ack", k, 1'b1);
    chk("radio block", radio_block, 1'b1);
  endtask : addr
  // Poll until programming ends, then read the current address
  task automatic poll(input logic e2, input logic [15:0] nxt);
    logic k;
    logic [7:0] d;
    int tries;
    tries = 0;
    k = 1'b0;
    while (!k && tries < 20) begin
      sel(e2, 1'b1, k);
      if (!k) u_mst.stop();
      tries++;
    end
    chk("busy nack", 16'(tries > 1), 1'b1);
    chk("poll ack", k, 1'b1);
    u_mst.rbyte(1'b0, d);
    u_mst.stop();
    if (mem.exists({e2, nxt[12:0]})) chk("current addr", d, mem[{e2, nxt[12:0]}]);
  endtask : poll
  // Byte or page write of n random bytes; lk means data must be refused
  task automatic wr(input logic e2, input logic [15:0] a, input int n, input logic lk);
    logic k;
    logic [7:0] d;
    logic [15:0] ad;
    addr(e2, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ad = {a[15:2], 2'(a[1:0] + 2'(i))}; // Wraps inside the row
      u_mst.wbyte(d, k);
      chk("data ack", k, !lk);
      if (!lk) mem[{e2, ad[12:0]}] = d;
    end
    u_mst.stop();
    if (!lk) poll(e2, ad + 16'h0001);
  endtask : wr
  // Random read then sequential read of n bytes
  task automatic rd(input logic e2, input logic [15:0] a, input int n);
    logic k;
    logic [7:0] d;
    logic [15:0] ad;
    addr(e2, a);
    sel(e2, 1'b1, k);
    chk("read select ack", k, 1'b1);
    for (int i = 0; i < n; i++) begin
      ad = a + 16'(i);
      u_mst.rbyte(i < n - 1, d);
      chk("read data", d, mem[{e2, ad[12:0]}]);
    end
    u_mst.stop();
    chk("standby", radio_block, 1'b0);
  endtask : rd
  // Verdict, in one place for the tests and the watchdog
  task automatic end_sim();
    $display("compares %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the expected run of about 16k cycles
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    $display("watchdog expired");
    end_sim();
  end
  // Main sequence
  initial begin
    logic k;
    logic [7:0] sb;
    void'($urandom(32'hd4ef));
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("reset release", sda_oe_n, 1'b1);
    wr(1'b0, 16'h004c, 4, 1'b0); // Plain page
    wr(1'b0, 16'h004a, 4, 1'b0); // Page that wraps in its row
    wr(1'b0, 16'h0047, 1, 1'b0); // Byte write
    rd(1'b0, 16'h0047, 5); // Sequential read across rows
    $display("test write and read done");
    wr(1'b1, 16'h0047, 1, 1'b0);
    rd(1'b1, 16'h0047, 1);
    rd(1'b0, 16'h0047, 1);
    $display("test system area done");
    write_lock = 1'b1;
    wr(1'b0, 16'h004c, 2, 1'b1);
    rd(1'b0, 16'h004c, 4);
    unlock_key_valid = 1'b1;
    wr(1'b0, 16'h0048, 1, 1'b0);
    $display("test write lock done");
    for (int i = 0; i < 2; i++) begin
      u_mst.start();
      u_mst.wbyte(i == 0 ? 8'hb6 : 8'ha2, k);
      chk("bad select nack", k, 1'b0);
      u_mst.stop();
      chk("bad select idle", radio_block, 1'b0);
    end
    $display("test bad select done");
    u_mst.hold_hi(20);
    chk("after start", radio_block, 1'b1);
    u_mst.w(STMO);
    chk("start timeout", radio_block, 1'b0);
    u_mst.stop();
    // Clock lowered after the Start: the limit still counts from the Start
    u_mst.start();
    u_mst.w(STMO - 2);
    chk("start timeout low", radio_block, 1'b0);
    u_mst.stop();
    // Clock stuck low while the device holds its select ack
    sb = 8'ha6;
    u_mst.start();
    for (int i = 7; i >= 0; i--) u_mst.bit_cyc(sb[i], k);
    u_mst.w(10);
    chk("ack held", sda_oe_n, 1'b0);
    u_mst.w(TMO + 10);
    chk("clock low timeout", radio_block, 1'b0);
    chk("timeout release", sda_oe_n, 1'b1);
    u_mst.stop();
    // Clock stuck high after one bit
    u_mst.start();
    u_mst.bit_cyc(1'b0, k);
    u_mst.scl_hi();
    u_mst.w(TMO + 20);
    chk("clock high timeout", radio_block, 1'b0);
    u_mst.stop();
    rd(1'b0, 16'h004c, 1);
    $display("test timeouts done");
    end_sim();
  end
endmodule : ees_i2c_port_tb_top
`default_nettype wire

/* File: test/ees_master.sv */
// Bus master model: drives the serial clock and its half of the data line.
// Assumes the bench resolves the wire-AND data line and feeds it back here.
`timescale 1ns/1ps
`default_nettype none
module ees_master #(
  parameter int H = 8
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // Both lines idle high, as with the pull-ups
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Wait n falling edges, so no change lands on the sampling edge
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // One bit slot; data moves only while the clock is low
  task automatic bit_cyc(input logic b, output logic s);
    sda_m = b;
    w(H);
    scl = 1'b1;
    w(H);
    s = sda;
    scl = 1'b0;
    w(2); // Hold data past the clock fall
  endtask : bit_cyc
  // Start or repeated start
  task automatic start();
    sda_m = 1'b1;
    w(H);
    scl = 1'b1;
    w(H);
    sda_m = 1'b0;
    w(H);
    scl = 1'b0;
    w(2);
  endtask : start
  // Stop: data rises while clock high
  task automatic stop();
    sda_m = 1'b0;
    w(H);
    scl = 1'b1;
    w(H);
    sda_m = 1'b1;
    w(H);
  endtask : stop
  // Send a byte, most significant bit first, release for the ack slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
    bit_cyc(1'b1, s);
    ack = !s;
  endtask : wbyte
  // Receive a byte, then ack low or leave the line high to end
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_cyc(1'b1, s);
      d = {d[6:0], s};
    end
    bit_cyc(!ack, s);
  endtask : rbyte
  // Raise the clock and leave it high
  task automatic scl_hi();
    scl = 1'b1;
  endtask : scl_hi
  // Start, then leave the clock high for n cycles
  task automatic hold_hi(input int n);
    sda_m = 1'b0;
    w(n);
  endtask : hold_hi
endmodule : ees_master
`default_nettype wire
